// ---- sim/uiet_peer.sv ----
// usb bus peer model: line levels, frame markers and bus reset
`timescale 1ns/10ps
module uiet_peer (
   input wire logic aclk,
   input wire logic attached,
   output logic line_dp,
   output logic line_dm,
   output logic frame_strobe,
   output logic [10:0] frame_number,
   output logic usb_reset_seen
);
   // attached peer idles in the j state; pull-downs take both lines low when it leaves
   assign line_dp = attached;
   assign line_dm = 1'b0;
   initial begin
      frame_strobe = 1'b0;
      frame_number = 11'h000;
      usb_reset_seen = 1'b0;
   end
   // number only counts with the strobe, so it is inverted afterwards to catch late loads
   task automatic sof(input logic [10:0] n);
      @(posedge aclk);
      frame_number <= n;
      frame_strobe <= 1'b1;
      @(posedge aclk);
      frame_number <= ~n;
      frame_strobe <= 1'b0;
   endtask
   task automatic reset_bus();
      @(posedge aclk);
      usb_reset_seen <= 1'b1;
      @(posedge aclk);
      usb_reset_seen <= 1'b0;
   endtask
endmodule // uiet_peer

// ---- sim/uiet_regs_properties.sv ----
// concurrent checks on the usb register slice ports
`timescale 1ns/10ps
module uiet_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire uiet_pkg::uiet_flags_t general_irq_flags,
   input wire logic session_bit,
   input wire logic resume_signal,
   input wire logic in_suspend,
   input wire logic ep0_copy_done,
   input wire logic usb_irq,
   input wire logic resume_set,
   input wire logic host_role,
   input wire logic ep0_copy_req
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [8:0] f;
   // flat view of the flags, resume at 1, babble at 2
   assign f = general_irq_flags;
   // ****
   // properties
   // ****
   a_irq_after_reset: assert property ($rose(aresetn) |-> usb_irq == (f[1] | f[2]))
      else $error("irq wrong with reset mask");
   a_irq_idle: assert property (f == 9'h000 |-> !usb_irq)
      else $error("irq without flags");
   a_resume_gate: assert property (resume_set == (resume_signal && in_suspend))
      else $error("resume flag outside suspend");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_copy_clear: assert property (ep0_copy_req && ep0_copy_done |=>
      !ep0_copy_req || $rose(s_axi_bvalid))
      else $error("loopback bit not cleared");
   a_session_end: assert property (!session_bit |=> !host_role)
      else $error("host role without session");
endmodule // uiet_checker

bind uiet_regs uiet_checker uiet_checker_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .general_irq_flags, .session_bit, .resume_signal, .in_suspend,
   .ep0_copy_done, .usb_irq, .resume_set, .host_role, .ep0_copy_req);

// ---- sim/usb_irq_enable_frame_index_test_tb.sv ----
// self-checking bench for the usb register slice
`timescale 1ns/10ps
module usb_irq_enable_frame_index_test_tb;
   typedef struct {logic [9:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} uiet_row_t;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, frame_strobe;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf, endpoint_selector_field;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   uiet_pkg::uiet_flags_t general_irq_flags = 9'h000;
   logic session_bit = 1'b0, a_side = 1'b0, resume_signal = 1'b0, in_suspend = 1'b0;
   logic ep0_copy_done = 1'b0, attached = 1'b0, line_dp, line_dm, usb_reset_seen;
   logic usb_irq, resume_set, host_role, role_b_side_bit, full_speed, ep0_copy_req;
   logic [10:0] frame_number;
   uiet_pkg::uiet_buf_t selected_buf;
   int n_errors = 0, checked = 0, stall = 0;
   uiet_row_t rows [7] = '{
      '{uiet_pkg::IDX_IRQ_MASK, 32'ha5, 32'ha5, 2'h0},
      '{uiet_pkg::IDX_FRAME, 32'h1234, 32'h0, 2'h0},
      '{uiet_pkg::IDX_TEST, 32'h3f, 32'h20, 2'h0},
      '{uiet_pkg::IDX_EP_SEL, 32'hfff7, 32'h7, 2'h0},
      '{uiet_pkg::IDX_TX_SIZE, 32'hff, 32'hf, 2'h0},
      '{uiet_pkg::IDX_RX_START, 32'hffff, 32'h1fff, 2'h0},
      '{10'h3ff, 32'h1, 32'h0, uiet_pkg::RESP_SLVERR}};

   uiet_regs uiet_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .general_irq_flags, .frame_strobe, .frame_number,
      .session_bit, .a_side, .line_dp, .line_dm, .usb_reset_seen, .resume_signal, .in_suspend,
      .ep0_copy_done, .usb_irq, .resume_set, .host_role, .role_b_side_bit, .full_speed,
      .ep0_copy_req, .endpoint_selector_field, .selected_buf);
   uiet_peer uiet_peer_inst (.aclk, .attached, .line_dp, .line_dm, .frame_strobe,
      .frame_number, .usb_reset_seen);

   // 125 mhz clock
   always #4 aclk = ~aclk;

   // ****
   // shared tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // a stalled master raises bready late, which the slave must ride out
   task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      n = 0;
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (stall == 0);
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready && n > stall) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
      chk(n < 60, 1'b1);
      rs = s_axi_bresp;
   endtask
   task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      n = 0;
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (stall == 0);
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready && n > stall) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
      chk(n < 60, 1'b1);
      d = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task automatic rc(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] rs;
      rd(a, d, rs);
      chk(d, e);
      chk(rs, uiet_pkg::RESP_OKAY);
   endtask
   task automatic role(input logic e);
      int n;
      n = 0;
      while (host_role !== e && n < 20) begin
         @(posedge aclk);
         n++;
      end
      chk(host_role, e);
   endtask
   // one source at a time against one enable at a time
   task automatic sweep(input logic host);
      logic [8:0] fl;
      logic [7:0] view;
      logic [1:0] rs;
      for (int i = 0; i < 8; i++) begin
         wr(uiet_pkg::IDX_IRQ_MASK, 32'h1 << i, rs);
         for (int j = 0; j < 9; j++) begin
            fl = 9'h001 << j;
            general_irq_flags <= fl;
            view = {fl[8:4], host ? fl[3] : fl[2], fl[1:0]};
            @(negedge aclk);
            chk(usb_irq, view[i]);
            @(posedge aclk);
         end
      end
      general_irq_flags <= 9'h000;
   endtask
   task automatic conclude();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****
   // test sequence
   // ****
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(uiet_pkg::IDX_IRQ_MASK, 32'h06);
      rc(uiet_pkg::IDX_FRAME, 32'h0);
      rc(uiet_pkg::IDX_EP_SEL, 32'h0);
      rc(uiet_pkg::IDX_TEST, 32'h0);
      rc(uiet_pkg::IDX_TX_START, 32'h0);
      $display("done reset values");
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d, r);
         chk(r, rows[k].r);
         rd(rows[k].a, v, r);
         chk(v, rows[k].e);
         chk(r, rows[k].r);
      end
      $display("done table");
      wr(uiet_pkg::IDX_EP_SEL, 32'h3, r);
      wr(uiet_pkg::IDX_TX_SIZE, 32'h9, r);
      rc(uiet_pkg::IDX_TX_SIZE, 32'h9);
      chk(selected_buf.tx_size, 4'h9);
      chk(endpoint_selector_field, 4'h3);
      wr(uiet_pkg::IDX_EP_SEL, 32'h7, r);
      rc(uiet_pkg::IDX_TX_SIZE, 32'hf);
      uiet_peer_inst.sof(11'h7ff);
      rc(uiet_pkg::IDX_FRAME, 32'h7ff);
      $display("done index and frame");
      sweep(1'b0);
      resume_signal <= 1'b1;
      @(negedge aclk);
      chk(resume_set, 1'b0);
      @(posedge aclk);
      in_suspend <= 1'b1;
      @(negedge aclk);
      chk(resume_set, 1'b1);
      @(posedge aclk);
      $display("done device mask");
      wr(uiet_pkg::IDX_TEST, 32'h0, r);
      session_bit <= 1'b1;
      a_side <= 1'b1;
      repeat (8) @(posedge aclk);
      role(1'b0);
      attached <= 1'b1;
      role(1'b1);
      attached <= 1'b0;
      role(1'b0);
      wr(uiet_pkg::IDX_TEST, 32'h80, r);
      session_bit <= 1'b0;
      repeat (2) @(posedge aclk);
      session_bit <= 1'b1;
      role(1'b1);
      chk(role_b_side_bit, 1'b0);
      attached <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(role_b_side_bit, 1'b1);
      chk(full_speed, 1'b0);
      attached <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(host_role, 1'b1);
      sweep(1'b1);
      wr(uiet_pkg::IDX_TEST, 32'ha0, r);
      @(posedge aclk);
      chk(full_speed, 1'b1);
      session_bit <= 1'b0;
      role(1'b0);
      session_bit <= 1'b1;
      role(1'b1);
      session_bit <= 1'b0;
      $display("done role");
      wr(uiet_pkg::IDX_TEST, 32'h20, r);
      uiet_peer_inst.reset_bus();
      @(posedge aclk);
      chk(full_speed, 1'b1);
      wr(uiet_pkg::IDX_TEST, 32'h0, r);
      uiet_peer_inst.reset_bus();
      @(posedge aclk);
      chk(full_speed, 1'b0);
      stall = 3;
      wr(uiet_pkg::IDX_TEST, 32'h40, r);
      chk(ep0_copy_req, 1'b1);
      wr(uiet_pkg::IDX_TEST, 32'h0, r);
      rc(uiet_pkg::IDX_TEST, 32'h40);
      ep0_copy_done <= 1'b1;
      @(posedge aclk);
      ep0_copy_done <= 1'b0;
      @(posedge aclk);
      chk(ep0_copy_req, 1'b0);
      rc(uiet_pkg::IDX_TEST, 32'h0);
      stall = 0;
      $display("done speed and loopback");
      wr(uiet_pkg::IDX_IRQ_MASK, 32'hff, r);
      aresetn <= 1'b0;
      general_irq_flags <= 9'h004;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(usb_irq, 1'b1);
      @(posedge aclk);
      rc(uiet_pkg::IDX_IRQ_MASK, 32'h06);
      $display("done second reset");
      conclude();
   end

   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      n_errors++;
      $display("ERROR %0t: timeout", $time);
      conclude();
   end
endmodule // usb_irq_enable_frame_index_test_tb

// ---- verilog/uiet_pkg.sv ----
// constants and types for the usb interrupt mask, frame, index and test register slice
//
// Functional notes
// RULE1: eight-bit mask gates each status flag
// RULE2: mask resets to 0x06
// RULE3: host layout: fault, ask, drop, attach, sof...
// RULE4: device mode bit 2 enables babble instead
// RULE5: eleven-bit read-only last frame number
// RULE6: four-bit endpoint index selects indexed registers
// RULE7: per-endpoint transmit/receive buffer size and start
// RULE8: forced host enters host on session set
// RULE9: forced host ignores data line state
// RULE10: forced host holds until session clears
// RULE11: forced host reports attach, speed follows bit
// RULE12: writing one to bit 6 copies ep0 packet
// RULE13: hardware clears loopback bit when copy completes
// RULE14: bit 5 selects full speed at reset
// RULE15: software sets at most one test bit
// RULE16: test register only for compliance test modes
// RULE17: test register resets zero, bits 4:0 zero
// RULE18: resume flag only while suspended
// RULE19: interrupt is OR of masked flags
package uiet_pkg;

   // ******************************
   // register indices, byte address is four times the index
   // ******************************
   localparam logic [9:0] IDX_IRQ_MASK = 10'h00b;
   localparam logic [9:0] IDX_FRAME = 10'h00c;
   localparam logic [9:0] IDX_EP_SEL = 10'h00e;
   localparam logic [9:0] IDX_TEST = 10'h00f;
   localparam logic [9:0] IDX_TX_SIZE = 10'h062;
   localparam logic [9:0] IDX_RX_SIZE = 10'h063;
   localparam logic [9:0] IDX_TX_START = 10'h064;
   localparam logic [9:0] IDX_RX_START = 10'h066;

   // ******************************
   // reset values and field positions
   // ******************************
   localparam logic [7:0] RST_IRQ_MASK = 8'h06;
   localparam logic [10:0] RST_FRAME = 11'h000;
   localparam logic [3:0] RST_EP_SEL = 4'h0;
   localparam logic [2:0] RST_TEST = 3'h0;
   localparam logic [3:0] RST_BUF_SIZE = 4'h0;
   localparam logic [12:0] RST_BUF_START = 13'h0000;
   localparam int BIT_FORCED_HOST = 7;
   localparam int BIT_LOOPBACK = 6;
   localparam int BIT_FORCED_FS = 5;
   localparam int BIT_ALT_FLAG = 2;
   localparam int NUM_EP = 16;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // status flags from the interrupt status logic, one per source
   typedef struct packed {
      logic bus_power_fault;
      logic session_ask;
      logic link_drop_flag;
      logic attach_flag;
      logic start_of_frame;
      logic bus_reset;
      logic babble;
      logic resume;
      logic suspend;
   } uiet_flags_t;

   // one endpoint's buffer placement
   typedef struct packed {
      logic [3:0] tx_size;
      logic [3:0] rx_size;
      logic [12:0] tx_start;
      logic [12:0] rx_start;
   } uiet_buf_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } uiet_wr_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } uiet_rd_t;

endpackage

// ---- verilog/uiet_regs.sv ----
// axi4-lite register slice: interrupt mask, frame number, endpoint index, buffers, test modes
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
module uiet_regs (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // controller core side
   input wire uiet_pkg::uiet_flags_t general_irq_flags,
   input wire logic frame_strobe,
   input wire logic [10:0] frame_number,
   input wire logic session_bit,
   input wire logic a_side,
   input wire logic line_dp,
   input wire logic line_dm,
   input wire logic usb_reset_seen,
   input wire logic resume_signal,
   input wire logic in_suspend,
   input wire logic ep0_copy_done,
   output logic usb_irq,
   output logic resume_set,
   output logic host_role,
   output logic role_b_side_bit,
   output logic full_speed,
   output logic ep0_copy_req,
   output logic [3:0] endpoint_selector_field,
   output uiet_pkg::uiet_buf_t selected_buf
);

   // ******************************
   // data line synchronisers
   // ******************************
   logic [1:0] line_raw;
   logic [1:0] sync1_q, sync2_q, sync3_q, line_q;
   logic [1:0] sync1_d, sync2_d, sync3_d, line_d;

   assign line_raw = {line_dp, line_dm};

   // a line change counts only once the second and third stages agree
   genvar gl;
   generate
      for (gl = 0; gl < 2; gl++) begin : g_line
         always_comb begin
            sync1_d[gl] = line_raw[gl];
            sync2_d[gl] = sync1_q[gl];
            sync3_d[gl] = sync2_q[gl];
            line_d[gl] = (sync2_q[gl] == sync3_q[gl]) ? sync3_q[gl] : line_q[gl];
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         sync3_q <= 2'h0;
         line_q <= 2'h0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
         line_q <= line_d;
      end
   end

   // ******************************
   // axi4-lite write channel
   // ******************************
   uiet_pkg::uiet_wr_t wr_state_q, wr_state_d;
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [9:0] wr_idx_q, wr_idx_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d;
   logic wr_do;
   logic wr_hit;

   assign s_axi_awready = (wr_state_q == uiet_pkg::WR_COLLECT) && !aw_got_q;
   assign s_axi_wready = (wr_state_q == uiet_pkg::WR_COLLECT) && !w_got_q;
   assign s_axi_bvalid = (wr_state_q == uiet_pkg::WR_RESP);
   assign s_axi_bresp = bresp_q;
   // address and data may arrive in either order; the write lands once both are held
   assign wr_do = (wr_state_q == uiet_pkg::WR_COLLECT) && aw_got_q && w_got_q;
   assign wr_hit = (wr_idx_q == uiet_pkg::IDX_IRQ_MASK) || (wr_idx_q == uiet_pkg::IDX_FRAME) ||
                   (wr_idx_q == uiet_pkg::IDX_EP_SEL) || (wr_idx_q == uiet_pkg::IDX_TEST) ||
                   (wr_idx_q == uiet_pkg::IDX_TX_SIZE) || (wr_idx_q == uiet_pkg::IDX_RX_SIZE) ||
                   (wr_idx_q == uiet_pkg::IDX_TX_START) || (wr_idx_q == uiet_pkg::IDX_RX_START);

   // write handshake next state
   always_comb begin
      wr_state_d = wr_state_q;
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      wr_idx_d = wr_idx_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      case (wr_state_q)
         uiet_pkg::WR_COLLECT: begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_got_d = 1'b1;
               wr_idx_d = s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_got_d = 1'b1;
               wdata_d = s_axi_wdata;
               wstrb_d = s_axi_wstrb;
            end
            if (wr_do) begin
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               bresp_d = wr_hit ? uiet_pkg::RESP_OKAY : uiet_pkg::RESP_SLVERR;
               wr_state_d = uiet_pkg::WR_RESP;
            end
         end
         uiet_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_d = uiet_pkg::WR_COLLECT;
            end
         end
         default: begin
            wr_state_d = uiet_pkg::WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= uiet_pkg::WR_COLLECT;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         wr_idx_q <= 10'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= 2'h0;
      end else begin
         wr_state_q <= wr_state_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         wr_idx_q <= wr_idx_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
      end
   end

   // ******************************
   // software registers
   // ******************************
   logic [7:0] mask_q, mask_d;
   logic [10:0] frame_q, frame_d;
   logic [3:0] ep_sel_q, ep_sel_d;
   logic forced_host_bit, ep0_loopback_bit, forced_full_speed_bit;
   logic [2:0] test_q, test_d;
   uiet_pkg::uiet_buf_t buf_q [uiet_pkg::NUM_EP];
   uiet_pkg::uiet_buf_t buf_d [uiet_pkg::NUM_EP];
   logic wr_lo, wr_hi;

   assign wr_lo = wr_do && wstrb_q[0];
   assign wr_hi = wr_do && wstrb_q[1];
   assign forced_host_bit = test_q[2];
   assign ep0_loopback_bit = test_q[1];
   assign forced_full_speed_bit = test_q[0];

   // register next values; frame number is written only by the core
   always_comb begin
      mask_d = mask_q;
      frame_d = frame_q;
      ep_sel_d = ep_sel_q;
      test_d = test_q;
      if (wr_lo && (wr_idx_q == uiet_pkg::IDX_IRQ_MASK)) begin
         mask_d = wdata_q[7:0]; // RULE1
      end
      if (frame_strobe) begin
         frame_d = frame_number; // RULE5
      end
      if (wr_lo && (wr_idx_q == uiet_pkg::IDX_EP_SEL)) begin
         ep_sel_d = wdata_q[3:0]; // RULE6
      end
      // completion clears the loopback bit, but a new set in the same cycle wins
      if (ep0_copy_done) begin
         test_d[1] = 1'b0; // RULE13
      end
      if (wr_lo && (wr_idx_q == uiet_pkg::IDX_TEST)) begin
         test_d[2] = wdata_q[uiet_pkg::BIT_FORCED_HOST];
         test_d[0] = wdata_q[uiet_pkg::BIT_FORCED_FS]; // RULE14
         if (wdata_q[uiet_pkg::BIT_LOOPBACK]) begin
            test_d[1] = 1'b1; // RULE12
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= uiet_pkg::RST_IRQ_MASK; // RULE2
         frame_q <= uiet_pkg::RST_FRAME;
         ep_sel_q <= uiet_pkg::RST_EP_SEL;
         test_q <= uiet_pkg::RST_TEST; // RULE17
      end else begin
         mask_q <= mask_d;
         frame_q <= frame_d;
         ep_sel_q <= ep_sel_d;
         test_q <= test_d;
      end
   end

   // per-endpoint buffer placement, reached through the endpoint index
   genvar ge;
   generate
      for (ge = 0; ge < uiet_pkg::NUM_EP; ge++) begin : g_ep
         always_comb begin
            buf_d[ge] = buf_q[ge];
            if (ep_sel_q == 4'(ge)) begin
               if (wr_lo && (wr_idx_q == uiet_pkg::IDX_TX_SIZE)) begin
                  buf_d[ge].tx_size = wdata_q[3:0]; // RULE7
               end
               if (wr_lo && (wr_idx_q == uiet_pkg::IDX_RX_SIZE)) begin
                  buf_d[ge].rx_size = wdata_q[3:0]; // RULE7
               end
               if (wr_idx_q == uiet_pkg::IDX_TX_START) begin
                  if (wr_lo) buf_d[ge].tx_start[7:0] = wdata_q[7:0];
                  if (wr_hi) buf_d[ge].tx_start[12:8] = wdata_q[12:8];
               end
               if (wr_idx_q == uiet_pkg::IDX_RX_START) begin
                  if (wr_lo) buf_d[ge].rx_start[7:0] = wdata_q[7:0];
                  if (wr_hi) buf_d[ge].rx_start[12:8] = wdata_q[12:8];
               end
            end
         end
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               buf_q[ge] <= {uiet_pkg::RST_BUF_SIZE, uiet_pkg::RST_BUF_SIZE,
                             uiet_pkg::RST_BUF_START, uiet_pkg::RST_BUF_START};
            end else begin
               buf_q[ge] <= buf_d[ge];
            end
         end
      end
   endgenerate

   assign endpoint_selector_field = ep_sel_q; // RULE6
   assign selected_buf = buf_q[ep_sel_q];
   assign ep0_copy_req = ep0_loopback_bit; // RULE12

   // ******************************
   // axi4-lite read channel
   // ******************************
   uiet_pkg::uiet_rd_t rd_state_q, rd_state_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [9:0] rd_idx;

   assign rd_idx = s_axi_araddr[11:2];
   assign s_axi_arready = (rd_state_q == uiet_pkg::RD_IDLE);
   assign s_axi_rvalid = (rd_state_q == uiet_pkg::RD_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // read decode; reserved bits and unmapped words read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_idx)
         uiet_pkg::IDX_IRQ_MASK: rd_mux[7:0] = mask_q;
         uiet_pkg::IDX_FRAME: rd_mux[10:0] = frame_q; // RULE5
         uiet_pkg::IDX_EP_SEL: rd_mux[3:0] = ep_sel_q;
         uiet_pkg::IDX_TEST: rd_mux[7:5] = test_q; // RULE17
         uiet_pkg::IDX_TX_SIZE: rd_mux[3:0] = selected_buf.tx_size;
         uiet_pkg::IDX_RX_SIZE: rd_mux[3:0] = selected_buf.rx_size;
         uiet_pkg::IDX_TX_START: rd_mux[12:0] = selected_buf.tx_start;
         uiet_pkg::IDX_RX_START: rd_mux[12:0] = selected_buf.rx_start;
         default: rd_hit = 1'b0;
      endcase
   end

   // read handshake next state
   always_comb begin
      rd_state_d = rd_state_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      case (rd_state_q)
         uiet_pkg::RD_IDLE: begin
            if (s_axi_arvalid) begin
               rdata_d = rd_mux;
               rresp_d = rd_hit ? uiet_pkg::RESP_OKAY : uiet_pkg::RESP_SLVERR;
               rd_state_d = uiet_pkg::RD_RESP;
            end
         end
         uiet_pkg::RD_RESP: begin
            if (s_axi_rready) begin
               rd_state_d = uiet_pkg::RD_IDLE;
            end
         end
         default: begin
            rd_state_d = uiet_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= uiet_pkg::RD_IDLE;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end else begin
         rd_state_q <= rd_state_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ******************************
   // role and speed
   // ******************************
   logic host_q, host_d;
   logic fs_q, fs_d;
   logic attached;

   // any line away from idle-low counts as a peer attached
   assign attached = |line_q;

   // forced host latches on session and holds until session drops
   always_comb begin
      host_d = host_q;
      fs_d = fs_q;
      if (!session_bit) begin
         host_d = 1'b0; // RULE10
      end else if (forced_host_bit) begin
         host_d = 1'b1; // RULE8 RULE9
      end else if (!host_q) begin
         host_d = a_side && attached;
      end else begin
         host_d = attached;
      end
      if (usb_reset_seen) begin
         fs_d = forced_full_speed_bit; // RULE14
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         host_q <= 1'b0;
         fs_q <= 1'b0;
      end else begin
         host_q <= host_d;
         fs_q <= fs_d;
      end
   end

   assign host_role = host_q;
   // in forced host the role bit shows connection; speed comes straight from the test bit
   assign role_b_side_bit = forced_host_bit ? attached : !host_q; // RULE11
   assign full_speed = forced_host_bit ? forced_full_speed_bit : fs_q; // RULE11

   // ******************************
   // interrupt gating
   // ******************************
   logic [7:0] flag_vec;
   logic [7:0] gated;

   // bit 2 source depends on role, so one mask bit serves two flags
   assign flag_vec = {general_irq_flags.bus_power_fault, general_irq_flags.session_ask,
                      general_irq_flags.link_drop_flag, general_irq_flags.attach_flag,
                      general_irq_flags.start_of_frame,
                      host_q ? general_irq_flags.bus_reset : general_irq_flags.babble,
                      general_irq_flags.resume, general_irq_flags.suspend}; // RULE3 RULE4

   genvar gb;
   generate
      for (gb = 0; gb < 8; gb++) begin : g_gate
         assign gated[gb] = flag_vec[gb] & mask_q[gb]; // RULE1
      end
   endgenerate

   assign usb_irq = |gated; // RULE19
   // resume is only flagged while suspended; wakeups outside suspend are not events
   assign resume_set = resume_signal && in_suspend; // RULE18

endmodule // uiet_regs
